//--- swd_pkg.sv
// Purpose: shared constants and types for the supervisor watchdog and its spi host
// Assumes: 100 MHz core clock, 16-bit spi frames sent msb first
// Notes: frame = {data[15:8], write[7], address[6:0]}
// Functional notes
// - time-out or window mode, time-out default
// - settings change only in normal mode
// - init: long window after reset released
// - sleep/restart/fail-safe off, long window after
// - new timing restarts the timer
// - trigger is control write, acted at cs rise
// - seven periods 10..1000 ms, 200 ms default
// - failure: reset low, flags, restart or fail-safe
// - reset release: long window, then normal mode
// - development mode: watchdog off, no reset
// - configs 0/2 with limit: three resets max
// - time-out: trigger anytime, expiry resets
// - window: 60% closed, early trigger resets
// - good trigger restarts closed window
// - host triggers between 0.72 and 1.20 period
// - even parity over control byte, else ignored
// - parity is xor of frame bits 15..8
// - broken stop sequence clears stage b
// - entering normal by request clears both stop stages
// - stop trigger or normal re-enables, long window
// - stage a set twice clears itself
// - bus wake in stop restarts, irq, receive low
package swd_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned MS_NS         = 1000000;
  localparam int unsigned TICK_CYCLES   = MS_NS / CLK_PERIOD_NS;
  localparam int unsigned FRAME_BITS    = 16;
  localparam int unsigned WR_BIT        = 7;
  localparam logic [6:0]  ADDR_MODE     = 7'h01;
  localparam logic [6:0]  ADDR_CTRL     = 7'h03;
  localparam logic [6:0]  ADDR_WAKE     = 7'h04;
  // supervisor_control_reg fields
  localparam int unsigned CTL_WIN       = 0;
  localparam int unsigned CTL_PER       = 1;
  localparam int unsigned CTL_LIMIT     = 4;
  localparam int unsigned CTL_STG_A     = 5;
  localparam int unsigned CTL_BUS_WK    = 6;
  localparam int unsigned CTL_PAR       = 7;
  // wake_control_reg field
  localparam int unsigned WAKE_STG_B    = 0;
  localparam logic [2:0]  PERIOD_RST    = 3'h4;
  localparam logic [10:0] LONG_OPEN_WINDOW_TIME_MS = 11'h0c8;
  localparam logic [10:0] RST_DELAY_MS  = 11'h002;
  localparam logic [1:0]  MAX_WD_RESETS = 2'h3;
  localparam logic [1:0]  REQ_NORMAL    = 2'h0;
  localparam logic [1:0]  REQ_SLEEP     = 2'h1;
  localparam logic [1:0]  REQ_STOP      = 2'h2;
  localparam int unsigned SCLK_HALF_CYCLES = 8;
  // host avalon register map
  localparam logic [3:0]  HOST_CMD_OFF  = 4'h0;
  localparam logic [3:0]  HOST_STAT_OFF = 4'h4;
  localparam int unsigned CMD_DATA      = 0;
  localparam int unsigned CMD_ADDR      = 8;
  localparam int unsigned CMD_WRITE     = 15;
  localparam int unsigned CMD_AUTO_PAR  = 16;
  localparam int unsigned STAT_BUSY     = 0;
  localparam int unsigned STAT_RX       = 8;

  typedef enum logic [2:0] {
    ST_INIT     = 3'b000,
    ST_NORMAL   = 3'b001,
    ST_STOP     = 3'b010,
    ST_SLEEP    = 3'b011,
    ST_RESTART  = 3'b100,
    ST_FAILSAFE = 3'b101
  } swd_state_type;

  typedef enum logic [2:0] {
    HS_IDLE = 3'b000,
    HS_LOW  = 3'b001,
    HS_HIGH = 3'b010,
    HS_TAIL = 3'b011,
    HS_GAP  = 3'b100
  } swd_host_state_type;

  // supervisor_period in ms per period_select_field code
  function automatic logic [10:0] supervisor_period(input logic [2:0] sel);
    case (sel)
      3'h0:    return 11'h00a;
      3'h1:    return 11'h014;
      3'h2:    return 11'h032;
      3'h3:    return 11'h064;
      3'h4:    return 11'h0c8;
      3'h5:    return 11'h1f4;
      default: return 11'h3e8;
    endcase
  endfunction

  function automatic logic [10:0] scale_fifths(input logic [10:0] p, input logic [2:0] k);
    logic [13:0] t;
    t = 14'(p) * 14'(k);
    return 11'(t / 14'h005);
  endfunction
endpackage

//--- swd_link_if.sv
// Purpose: spi link between host controller and watchdog device
// Assumes: plain push-pull wires, host is master
// Notes: miso is driven low by the device while idle
`timescale 1ns/10ps
`default_nettype none
interface swd_link_if;
  logic sclk;
  logic chip_select_n;
  logic mosi;
  logic miso;
  modport host (output sclk, output chip_select_n, output mosi, input miso);
  modport dev  (input sclk, input chip_select_n, input mosi, output miso);
endinterface
`default_nettype wire

//--- swd_spi_slave.sv
// Purpose: 16-bit spi frame receiver and status shifter for the device
// Assumes: mode 0, msb first, pins asynchronous to core clock
// Notes: frame handed over only at chip select rise
`timescale 1ns/10ps
`default_nettype none
module swd_spi_slave (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  input  wire logic        i_sclk,
  input  wire logic        i_cs_n,
  input  wire logic        i_mosi,
  input  wire logic [7:0]  i_tx_byte,
  output logic             o_miso,
  output logic             o_frame_valid,
  output logic             o_frame_err,
  output logic [15:0]      o_frame
);
  logic [1:0]  sclk_s, cs_s, mosi_s;
  logic        sclk_d, cs_d;
  logic [15:0] rx_q, tx_q;
  logic [4:0]  bits_q;
  logic        rise, fall, cs_fall, cs_rise;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      sclk_s <= 2'h0;
      cs_s   <= 2'h3;
      mosi_s <= 2'h0;
      sclk_d <= 1'b0;
      cs_d   <= 1'b1;
    end else begin
      sclk_s <= {sclk_s[0], i_sclk};
      cs_s   <= {cs_s[0], i_cs_n};
      mosi_s <= {mosi_s[0], i_mosi};
      sclk_d <= sclk_s[1];
      cs_d   <= cs_s[1];
    end
  end

  assign rise    = sclk_s[1] & ~sclk_d;
  assign fall    = ~sclk_s[1] & sclk_d;
  assign cs_fall = ~cs_s[1] & cs_d;
  assign cs_rise = cs_s[1] & ~cs_d;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      rx_q   <= 16'h0000;
      tx_q   <= 16'h0000;
      bits_q <= 5'h00;
    end else if (cs_fall) begin
      bits_q <= 5'h00;
      tx_q   <= {i_tx_byte, 8'h00};
    end else if (!cs_s[1]) begin
      if (rise) begin
        rx_q <= {rx_q[14:0], mosi_s[1]};
        // saturate so an overlong frame is still caught
        if (bits_q != 5'h11) bits_q <= bits_q + 5'h01;
      end
      if (fall) tx_q <= {tx_q[14:0], 1'b0};
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_frame_valid <= 1'b0;
      o_frame_err   <= 1'b0;
      o_frame       <= 16'h0000;
    end else begin
      o_frame_valid <= cs_rise & (bits_q == 5'(swd_pkg::FRAME_BITS));
      o_frame_err   <= cs_rise & (bits_q != 5'(swd_pkg::FRAME_BITS));
      if (cs_rise) o_frame <= rx_q;
    end
  end

  assign o_miso = tx_q[15];
endmodule // swd_spi_slave
`default_nettype wire

//--- swd_device.sv
// Purpose: supervisory watchdog with system mode control, serviced over spi
// Assumes: i_bus_wake, i_config_sel, i_dev_mode come from core-clock logic
// Notes: timer counts 1 ms ticks; status byte shifts out on every frame
`timescale 1ns/10ps
`default_nettype none
module swd_device #(
  parameter int unsigned TICK_CYCLES = swd_pkg::TICK_CYCLES
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  swd_link_if.dev          link,
  input  wire logic [1:0]  i_config_sel,
  input  wire logic        i_dev_mode,
  input  wire logic        i_bus_wake,
  output logic             o_reset_out_n,
  output logic             o_bus_receive_out,
  output logic             o_wake_irq,
  output logic [1:0]       o_failure_flags,
  output logic             o_spi_fail
);
  localparam int unsigned TW = $clog2(TICK_CYCLES + 1);

  swd_pkg::swd_state_type st_q, st_d;
  logic [TW-1:0] tick_cnt_q;
  logic          tick;
  logic          rst_n_q, rst_n_d;
  logic [10:0]   dly_q, dly_d;
  logic          wd_on_q, long_q;
  logic [10:0]   cnt_q, period, limit;
  logic          win_q, limit_q, bus_wk_q, stage_a_q, stage_b_q;
  logic [2:0]    per_q;
  logic          spi_fail_q;
  logic [1:0]    fail_cnt_q, rst_cnt_q;
  logic          frm_valid, frm_err;
  logic [15:0]   frm;
  logic [7:0]    wdata, status;
  logic          wr, ctrl_wr, par_ok, trig_acc, cfg_wr_ok, wake_wr, mode_wr;
  logic          go_normal, go_stop, go_sleep, wake_restart, reprog;
  logic          closed, expired, supervisor_failure_flags, suppress, fail_reset, to_fs;
  logic          start_lw, run_d;

  always_ff @(posedge i_core_clk) begin
    if (i_rst || tick) tick_cnt_q <= '0;
    else tick_cnt_q <= tick_cnt_q + TW'(1);
  end
  assign tick = (tick_cnt_q == TW'(TICK_CYCLES - 1));

  assign status = {spi_fail_q, fail_cnt_q, wd_on_q, rst_n_q, st_q};

  swd_spi_slave u_spi (
    .i_core_clk    (i_core_clk),
    .i_rst         (i_rst),
    .i_sclk        (link.sclk),
    .i_cs_n        (link.chip_select_n),
    .i_mosi        (link.mosi),
    .i_tx_byte     (status),
    .o_miso        (link.miso),
    .o_frame_valid (frm_valid),
    .o_frame_err   (frm_err),
    .o_frame       (frm)
  );

  always_comb begin
    wdata     = frm[15:8];
    wr        = frm[swd_pkg::WR_BIT];
    par_ok    = ~^wdata;
    ctrl_wr   = frm_valid & wr & (frm[6:0] == swd_pkg::ADDR_CTRL);
    mode_wr   = frm_valid & wr & (frm[6:0] == swd_pkg::ADDR_MODE);
    wake_wr   = frm_valid & wr & (frm[6:0] == swd_pkg::ADDR_WAKE) & (st_q == swd_pkg::ST_NORMAL);
    // bad parity: no trigger, no setting change
    trig_acc  = ctrl_wr & par_ok & rst_n_q & (st_q == swd_pkg::ST_INIT ||
                st_q == swd_pkg::ST_NORMAL || st_q == swd_pkg::ST_STOP);
    cfg_wr_ok = trig_acc & (st_q == swd_pkg::ST_NORMAL);
    go_normal = mode_wr & (wdata[1:0] == swd_pkg::REQ_NORMAL) & rst_n_q &
                (st_q == swd_pkg::ST_INIT || st_q == swd_pkg::ST_STOP);
    go_stop   = mode_wr & (wdata[1:0] == swd_pkg::REQ_STOP) & (st_q == swd_pkg::ST_NORMAL);
    go_sleep  = mode_wr & (wdata[1:0] == swd_pkg::REQ_SLEEP) &
                (st_q == swd_pkg::ST_NORMAL || st_q == swd_pkg::ST_STOP);
    wake_restart = (st_q == swd_pkg::ST_STOP) & i_bus_wake & bus_wk_q;
    reprog    = cfg_wr_ok & ((wdata[swd_pkg::CTL_WIN] != win_q) ||
                (wdata[swd_pkg::CTL_PER +: 3] != per_q));
    period    = swd_pkg::supervisor_period(per_q);
    // nominal trigger sits mid open window, so the window ends at 1.4 periods
    if (long_q) limit = swd_pkg::LONG_OPEN_WINDOW_TIME_MS;
    else if (win_q) limit = swd_pkg::scale_fifths(period, 3'h7);
    else limit = period;
    closed    = win_q & ~long_q & (cnt_q < swd_pkg::scale_fifths(period, 3'h3));
    expired   = cnt_q >= limit;
    supervisor_failure_flags   = wd_on_q & ~i_dev_mode & ((trig_acc & closed & ~reprog) | expired);
    suppress  = limit_q & ~i_config_sel[0] & (rst_cnt_q == swd_pkg::MAX_WD_RESETS);
    fail_reset = supervisor_failure_flags & ~suppress;
    to_fs     = (i_config_sel == 2'h1) || (i_config_sel == 2'h3 && fail_cnt_q != 2'h0);
  end

  always_comb begin
    st_d    = st_q;
    rst_n_d = rst_n_q;
    dly_d   = dly_q;
    if (fail_reset) begin
      st_d    = to_fs ? swd_pkg::ST_FAILSAFE : swd_pkg::ST_RESTART;
      rst_n_d = 1'b0;
      dly_d   = 11'h000;
    end else begin
      case (st_q)
        swd_pkg::ST_INIT: begin
          if (!rst_n_q) begin
            if (tick) dly_d = dly_q + 11'h001;
            if (dly_q == swd_pkg::RST_DELAY_MS) rst_n_d = 1'b1;
          end else if (go_normal) begin
            st_d = swd_pkg::ST_NORMAL;
          end
        end
        swd_pkg::ST_NORMAL, swd_pkg::ST_STOP: begin
          if (go_stop) begin
            st_d = swd_pkg::ST_STOP;
          end else if (go_normal) begin
            st_d = swd_pkg::ST_NORMAL;
          end else if (go_sleep) begin
            st_d    = swd_pkg::ST_SLEEP;
            rst_n_d = 1'b0;
          end
        end
        swd_pkg::ST_RESTART: begin
          if (tick) dly_d = dly_q + 11'h001;
          if (dly_q == swd_pkg::RST_DELAY_MS) begin
            st_d    = swd_pkg::ST_NORMAL;
            rst_n_d = 1'b1;
          end
        end
        swd_pkg::ST_SLEEP, swd_pkg::ST_FAILSAFE: begin
          if (i_bus_wake) begin
            st_d  = swd_pkg::ST_RESTART;
            dly_d = 11'h000;
          end
        end
        default: st_d = swd_pkg::ST_INIT;
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      st_q    <= swd_pkg::ST_INIT;
      rst_n_q <= 1'b0;
      dly_q   <= 11'h000;
    end else begin
      st_q    <= st_d;
      rst_n_q <= rst_n_d;
      dly_q   <= dly_d;
    end
  end

  always_comb begin
    run_d    = rst_n_d & (st_d == swd_pkg::ST_INIT || st_d == swd_pkg::ST_NORMAL ||
               st_d == swd_pkg::ST_STOP);
    start_lw = ~fail_reset & (
               (st_q == swd_pkg::ST_INIT && !rst_n_q && rst_n_d) ||
               (st_q == swd_pkg::ST_RESTART && rst_n_d) ||
               (st_q == swd_pkg::ST_STOP && (go_normal || wake_restart ||
                (trig_acc && !wd_on_q))) ||
               (supervisor_failure_flags && suppress));
  end

  // watchdog timer
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      wd_on_q <= 1'b0;
      long_q  <= 1'b1;
      cnt_q   <= 11'h000;
    end else if (start_lw) begin
      wd_on_q <= ~i_dev_mode;
      long_q  <= 1'b1;
      cnt_q   <= 11'h000;
    end else if (!run_d || i_dev_mode) begin
      wd_on_q <= 1'b0;
    end else if (go_stop && stage_a_q && stage_b_q) begin
      wd_on_q <= 1'b0;
    end else if (trig_acc && wd_on_q) begin
      long_q <= 1'b0;
      cnt_q  <= 11'h000;
    end else if (wd_on_q && tick) begin
      cnt_q <= cnt_q + 11'h001;
    end
  end

  // settings are frozen outside normal mode
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      win_q    <= 1'b0;
      per_q    <= swd_pkg::PERIOD_RST;
      limit_q  <= 1'b0;
      bus_wk_q <= 1'b0;
    end else if (cfg_wr_ok) begin
      win_q    <= wdata[swd_pkg::CTL_WIN];
      per_q    <= wdata[swd_pkg::CTL_PER +: 3];
      limit_q  <= wdata[swd_pkg::CTL_LIMIT];
      bus_wk_q <= wdata[swd_pkg::CTL_BUS_WK];
    end
  end

  // stop-mode disable sequence
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      stage_a_q <= 1'b0;
      stage_b_q <= 1'b0;
    end else if (go_normal || (st_q == swd_pkg::ST_STOP && start_lw)) begin
      stage_a_q <= 1'b0;
      stage_b_q <= 1'b0;
    end else if (cfg_wr_ok) begin
      stage_a_q <= wdata[swd_pkg::CTL_STG_A] & ~stage_a_q;
    end else if (wake_wr) begin
      stage_b_q <= wdata[swd_pkg::WAKE_STG_B] & stage_a_q;
    end
  end

  // flags: a set in the same cycle as a clear wins
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      spi_fail_q <= 1'b0;
      fail_cnt_q <= 2'h0;
      rst_cnt_q  <= 2'h0;
    end else begin
      if (frm_err || (ctrl_wr && !par_ok)) spi_fail_q <= 1'b1;
      else if (frm_valid && !wr) spi_fail_q <= 1'b0;
      if (supervisor_failure_flags && fail_cnt_q != 2'h3) fail_cnt_q <= fail_cnt_q + 2'h1;
      if (fail_reset && rst_cnt_q != swd_pkg::MAX_WD_RESETS) rst_cnt_q <= rst_cnt_q + 2'h1;
      else if (trig_acc && wd_on_q && !supervisor_failure_flags) rst_cnt_q <= 2'h0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_wake_irq        <= 1'b0;
      o_bus_receive_out <= 1'b1;
    end else begin
      o_wake_irq <= wake_restart;
      if (wake_restart) o_bus_receive_out <= 1'b0;
      else if (st_q != swd_pkg::ST_STOP) o_bus_receive_out <= 1'b1;
    end
  end

  assign o_reset_out_n   = rst_n_q;
  assign o_failure_flags = fail_cnt_q;
  assign o_spi_fail      = spi_fail_q;
endmodule // swd_device
`default_nettype wire

//--- swd_host.sv
// Purpose: spi master that services the watchdog, driven over avalon-mm
// Assumes: sclk made here by a divider; miso synchronised before use
// Notes: a command write while busy is held off by waitrequest
`timescale 1ns/10ps
`default_nettype none
module swd_host #(
  parameter int unsigned HALF = swd_pkg::SCLK_HALF_CYCLES
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  swd_link_if.host         link,
  input  wire logic [3:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest
);
  swd_pkg::swd_host_state_type st_q;
  logic [7:0]  cnt_q;
  logic [3:0]  bit_q;
  logic [15:0] sh_q, rx_q;
  logic [7:0]  rx_byte_q;
  logic [1:0]  miso_s;
  logic        rd_ack_q, busy, start, half_done;
  logic [7:0]  data;

  assign busy              = (st_q != swd_pkg::HS_IDLE);
  assign o_avs_waitrequest = (i_avs_read & ~rd_ack_q) | (i_avs_write & busy);
  assign start     = i_avs_write & ~busy & (i_avs_address == swd_pkg::HOST_CMD_OFF);
  assign half_done = (cnt_q == 8'(HALF - 1));

  always_comb begin
    data = i_avs_writedata[swd_pkg::CMD_DATA +: 8];
    // even parity over the control byte, parity bit included
    if (i_avs_writedata[swd_pkg::CMD_AUTO_PAR])
      data[swd_pkg::CTL_PAR] = ^data[6:0];
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) miso_s <= 2'h0;
    else miso_s <= {miso_s[0], link.miso};
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst || st_q == swd_pkg::HS_IDLE || half_done) cnt_q <= 8'h00;
    else cnt_q <= cnt_q + 8'h01;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      st_q               <= swd_pkg::HS_IDLE;
      link.sclk          <= 1'b0;
      link.chip_select_n <= 1'b1;
      link.mosi          <= 1'b0;
      bit_q              <= 4'h0;
      sh_q               <= 16'h0000;
      rx_q               <= 16'h0000;
      rx_byte_q          <= 8'h00;
    end else begin
      case (st_q)
        swd_pkg::HS_IDLE: if (start) begin
          sh_q <= {data, i_avs_writedata[swd_pkg::CMD_WRITE],
                   i_avs_writedata[swd_pkg::CMD_ADDR +: 7]};
          link.mosi          <= data[7];
          link.chip_select_n <= 1'b0;
          bit_q              <= 4'h0;
          st_q               <= swd_pkg::HS_LOW;
        end
        swd_pkg::HS_LOW: if (half_done) begin
          link.sclk <= 1'b1;
          rx_q      <= {rx_q[14:0], miso_s[1]};
          st_q      <= swd_pkg::HS_HIGH;
        end
        swd_pkg::HS_HIGH: if (half_done) begin
          link.sclk <= 1'b0;
          if (bit_q == 4'hf) begin
            st_q <= swd_pkg::HS_TAIL;
          end else begin
            bit_q     <= bit_q + 4'h1;
            sh_q      <= {sh_q[14:0], 1'b0};
            link.mosi <= sh_q[14];
            st_q      <= swd_pkg::HS_LOW;
          end
        end
        swd_pkg::HS_TAIL: if (half_done) begin
          link.chip_select_n <= 1'b1;
          rx_byte_q          <= rx_q[15:8];
          st_q               <= swd_pkg::HS_GAP;
        end
        swd_pkg::HS_GAP: if (half_done) st_q <= swd_pkg::HS_IDLE;
        default: st_q <= swd_pkg::HS_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      rd_ack_q       <= 1'b0;
      o_avs_readdata <= 32'h0000_0000;
    end else begin
      rd_ack_q <= i_avs_read & ~rd_ack_q;
      if (i_avs_read && !rd_ack_q) begin
        if (i_avs_address == swd_pkg::HOST_STAT_OFF)
          o_avs_readdata <= {16'h0000, rx_byte_q, 7'h00, busy};
        else
          o_avs_readdata <= 32'h0000_0000;
      end
    end
  end
endmodule // swd_host
`default_nettype wire

//--- swd_link_sva.sv
// Purpose: wire-level checks on the spi link between host and watchdog
// Assumes: host half period of 8 core cycles, 16-bit frames
// Notes: sees only the link signals plus core clock and reset
`timescale 1ns/10ps
`default_nettype none
module swd_link_sva (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_sclk,
  input wire logic i_chip_select_n,
  input wire logic i_mosi,
  input wire logic i_miso
);
  logic       sclk_q;
  logic [4:0] rise_q;
  // counts sclk rises inside one frame, cleared while deselected
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      sclk_q <= 1'b0;
      rise_q <= 5'h00;
    end else begin
      sclk_q <= i_sclk;
      if (i_chip_select_n) rise_q <= 5'h00;
      else if (i_sclk && !sclk_q) rise_q <= rise_q + 5'h01;
    end
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  property p_idle; i_chip_select_n |-> !i_sclk; endproperty
  a_idle: assert property (p_idle) else $error("sclk high outside frame");
  property p_hi; $rose(i_sclk) |-> i_sclk [*8]; endproperty
  a_hi: assert property (p_hi) else $error("sclk high phase short");
  property p_lo; $fell(i_sclk) |-> !i_sclk [*8]; endproperty
  a_lo: assert property (p_lo) else $error("sclk low phase short");
  property p_mosi; $changed(i_mosi) |-> !i_sclk; endproperty
  a_mosi: assert property (p_mosi) else $error("mosi moved while sclk high");
  property p_cnt; $rose(i_chip_select_n) |-> rise_q == 5'h10; endproperty
  a_cnt: assert property (p_cnt) else $error("frame without 16 clocks");
  property p_len; $fell(i_chip_select_n) |-> ##[200:320] $rose(i_chip_select_n); endproperty
  a_len: assert property (p_len) else $error("frame length off");
  property p_gap; $rose(i_chip_select_n) |-> i_chip_select_n [*8]; endproperty
  a_gap: assert property (p_gap) else $error("select gap too short");
  property p_miso; i_chip_select_n [*8] |-> !i_miso; endproperty
  a_miso: assert property (p_miso) else $error("miso not low when idle");
  c_frame: cover property ($rose(i_chip_select_n));
  c_miso: cover property (i_miso);
  c_full: cover property (rise_q == 5'h10);
endmodule // swd_link_sva
`default_nettype wire

//--- sbc_window_timeout_watchdog_tb.sv
// Purpose: drives host over avalon, watches device supervisor outputs
// Assumes: config 0, one bus wake pulse in stop, 20 core cycles per ms tick
// Notes: model keeps failure count; spi failure flag is checked against fixed values
`timescale 1ns/10ps
`default_nettype none
module sbc_window_timeout_watchdog_tb;
  localparam int TK = 20;
  logic clk = 1'b0, rst = 1'b1, dev = 1'b0, rd = 1'b0, wr = 1'b0, wq, rn, sf_o;
  logic bw = 1'b0, ir, rc;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wd = 32'h0, rdat, seed = 32'd26641;
  logic [1:0]  fl_o;
  logic [7:0]  st;
  int err_count = 0, checked = 0, fl = 0;
  always #5 clk = ~clk;
  swd_link_if u_swd_link_if ();
  swd_host u_swd_host (.i_core_clk(clk), .i_rst(rst), .link(u_swd_link_if), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wq));
  swd_device #(.TICK_CYCLES(TK)) u_swd_device (.i_core_clk(clk), .i_rst(rst),
    .link(u_swd_link_if), .i_config_sel(2'h0), .i_dev_mode(dev), .i_bus_wake(bw),
    .o_reset_out_n(rn), .o_bus_receive_out(rc), .o_wake_irq(ir), .o_failure_flags(fl_o),
    .o_spi_fail(sf_o));
  swd_link_sva u_swd_link_sva (.i_core_clk(clk), .i_rst(rst), .i_sclk(u_swd_link_if.sclk),
    .i_chip_select_n(u_swd_link_if.chip_select_n), .i_mosi(u_swd_link_if.mosi),
    .i_miso(u_swd_link_if.miso));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic ck(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic av(input logic [3:0] a, input logic w, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge clk);
    adr <= a; rd <= !w; wr <= w; wd <= d;
    // request stands until the edge that samples waitrequest low
    do @(posedge clk); while (wq !== 1'b0);
    q = rdat;
    rd <= 1'b0; wr <= 1'b0;
  endtask
  // one spi frame; waits until the host reports idle
  task automatic fr(input logic [6:0] a, input logic w, input logic [7:0] d, input logic p);
    logic [31:0] q;
    av(4'h0, 1'b1, {15'h0, p, w, a, d}, q);
    q = 32'h1;
    while (q[0] !== 1'b0) av(4'h4, 1'b0, 32'h0, q);
    st = q[15:8];
  endtask
  task automatic hold(input logic v, input int n);
    int b;
    b = 0;
    repeat (n) begin @(negedge clk); if (rn !== v) b++; end
    ck((b != 0) ? 8'h1 : 8'h0, 8'h0);
  endtask
  task automatic wt(input logic v, input int n);
    int i;
    i = 0;
    while (rn !== v && i < n) begin @(negedge clk); i++; end
    ck({7'h0, rn}, {7'h0, v});
  endtask
  task automatic dn(input int t);
    $display("test %0d done", t);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #600000;
    err_count++;
    stop_test();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    hold(1'b0, 30);
    wt(1'b1, 100);
    fr(7'h01, 1'b1, 8'h00, 1'b0);
    dn(1);
    fr(7'h03, 1'b1, 8'h80, 1'b0);
    ck({7'h0, sf_o}, 8'h01);
    fr(7'h03, 1'b0, 8'(xs()), 1'b0);
    ck({7'h0, sf_o}, 8'h00);
    dn(2);
    fr(7'h03, 1'b1, 8'h68, 1'b1);
    fr(7'h04, 1'b1, 8'h01, 1'b0);
    fr(7'h01, 1'b1, 8'h02, 1'b0);
    fr(7'h03, 1'b0, 8'(xs()), 1'b0);
    ck(st, 8'h0a);
    @(posedge clk);
    bw <= 1'b1;
    @(posedge clk);
    bw <= 1'b0;
    @(negedge clk);
    ck({6'h0, ir, rc}, 8'h02);
    fr(7'h03, 1'b0, 8'(xs()), 1'b0);
    ck(st, 8'h1a);
    fr(7'h01, 1'b1, 8'h00, 1'b0);
    fr(7'h03, 1'b0, 8'(xs()), 1'b0);
    ck(st, 8'h19);
    ck({7'h0, rc}, 8'h01);
    dn(7);
    fr(7'h03, 1'b1, 8'h00, 1'b1);
    hold(1'b1, 10 * TK - 50);
    wt(1'b0, 100);
    fl = 1;
    ck({6'h0, fl_o}, fl[7:0]);
    wt(1'b1, 100);
    fr(7'h03, 1'b0, 8'(xs()), 1'b0);
    ck(st, {1'b0, fl[1:0], 5'h19});
    dn(3);
    fr(7'h03, 1'b1, 8'h05, 1'b1);
    fr(7'h03, 1'b1, 8'h05, 1'b1);
    wt(1'b0, 60);
    fl = 2;
    ck({6'h0, fl_o}, fl[7:0]);
    wt(1'b1, 100);
    dn(4);
    fr(7'h03, 1'b1, 8'h15, 1'b1);
    repeat (3) begin
      hold(1'b1, 25 * TK);
      fr(7'h03, 1'b1, 8'h15, 1'b1);
    end
    hold(1'b1, 55 * TK);
    wt(1'b0, 20 * TK);
    fl = 3;
    ck({6'h0, fl_o}, fl[7:0]);
    dn(5);
    // limit bit set: two more untriggered long windows reset, the next one may not
    repeat (2) begin
      wt(1'b1, 100);
      hold(1'b1, 190 * TK);
      wt(1'b0, 20 * TK);
    end
    wt(1'b1, 100);
    hold(1'b1, 210 * TK);
    ck({6'h0, fl_o}, 8'h03);
    dn(8);
    @(posedge clk);
    dev <= 1'b1;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wt(1'b1, 200);
    hold(1'b1, 450 * TK);
    ck({6'h0, fl_o}, 8'h00);
    dn(6);
    stop_test();
  end
endmodule // sbc_window_timeout_watchdog_tb
`default_nettype wire
